// file: logic/boot_loader_pkg.sv
// Package with script codes, header layout and timing constants for the boot loader
package boot_loader_pkg;
  localparam logic [31:0] START_MARKER     = 32'ha5a5a5a5;
  localparam logic [31:0] EMPTY_WORD       = 32'hffffffff;
  localparam logic [31:0] EMPTY_WORD_SHORT = 32'h0fffffff;
  localparam logic [31:0] DEBUG_OFF_WORD   = 32'h70000000;
  localparam logic [31:0] SPI_FAST_WORD    = 32'ha0000000;
  localparam logic [3:0]  NIB_CALIB        = 4'h9;
  localparam logic [3:0]  NIB_SYNC_TIMEOUT = 4'h8;
  localparam logic [15:0] CALIB_TOP        = 16'h9000;
  localparam int          CALIB_CNT_LSB    = 8;
  localparam int          CALIB_CNT_MSB    = 15;
  localparam int          NIB_MSB          = 31;
  localparam int          NIB_LSB          = 28;
  localparam int          TIMEOUT_MSB      = 27;
  localparam int          SCRIPT_DEPTH     = 60;
  localparam logic [31:0] APP_FLAG1        = 32'h1234a5a5;
  localparam logic [31:0] APP_FLAG2        = 32'ha5a51234;
  localparam logic [7:0]  SPECIFIC_BOOT    = 8'haa;
  localparam int          UART_SEL_MSB     = 31;
  localparam int          UART_SEL_LSB     = 24;
  localparam logic [7:0]  UART_SEL_TWO     = 8'h00;
  localparam logic [7:0]  UART_SEL_ONE_A   = 8'h01;
  localparam logic [7:0]  UART_SEL_ONE_B   = 8'h02;
  localparam int          SCAN_STEPS       = 6;
  // Word indices of the header fields inside the header window
  localparam logic [3:0]  HDR_FLAG1        = 4'h0;
  localparam logic [3:0]  HDR_FLAG2        = 4'h1;
  localparam logic [3:0]  HDR_BOOTCFG      = 4'h2;
  localparam logic [3:0]  HDR_DMA_LEN      = 4'h7;
  // Timing
  localparam int          CLK_PERIOD_NS    = 100;
  localparam int          TIMEOUT_UNIT_US  = 100;
  localparam int          UNIT_CYCLES      = (TIMEOUT_UNIT_US * 1000) / CLK_PERIOD_NS;
  localparam logic [27:0] DEFAULT_TIMEOUT  = 28'h0000028;
  localparam logic [7:0]  BAUD_115K2_DIV   = 8'h57;
  localparam logic [1:0]  SPI_CLK_2MHZ     = 2'h0;
  localparam logic [1:0]  SPI_CLK_32MHZ    = 2'h1;
  typedef enum logic [1:0] {UART_TWO_WIRE, UART_ONE_WIRE_A, UART_ONE_WIRE_B} uart_mode_t;
endpackage

// file: logic/boot_timeout.sv
// Step timeout: counts 100 us units and flags expiry
`timescale 1ns/1ps
`default_nettype none
module boot_timeout #(
  parameter int UNIT_CYC = boot_loader_pkg::UNIT_CYCLES
) (
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        reset,
  // Control
  input  wire logic        start,
  input  wire logic [27:0] limit,
  // Status
  output logic             expired
);
  logic [15:0] unit_reg;
  logic [27:0] count_reg;
  logic        run_reg;

  always_ff @(posedge clk_sys)
  begin
    if (reset || start)
    begin
      unit_reg  <= 16'h0000;
      count_reg <= 28'h0000000;
      run_reg   <= start;
    end
    else if (run_reg)
    begin
      if (unit_reg == 16'(UNIT_CYC - 1))
      begin
        unit_reg  <= 16'h0000;
        count_reg <= count_reg + 28'h0000001;
      end
      else
        unit_reg <= unit_reg + 16'h0001;
      // Stop on the same condition that flags expiry, or a zero limit never expires
      if (expired)
        run_reg <= 1'b0;
    end
  end

  // Zero limit still waits one unit so a step never times out instantly
  assign expired = run_reg && (count_reg >= limit) && (limit != 28'h0000000 || count_reg != 28'h0000000);
endmodule // boot_timeout
`default_nettype wire

// file: logic/script_decoder.sv
// Classifies one configuration script word by its full value, its top half-word or its top nibble
`timescale 1ns/1ps
`default_nettype none
module script_decoder (
  // Word in
  input  wire logic [31:0] word,
  // Class out
  output logic             is_empty,
  output logic             is_calib,
  output logic             is_debug_off,
  output logic             is_timeout,
  output logic             is_spi_fast,
  output logic [7:0]       calib_count
);
  always_comb
  begin
    is_empty     = (word == boot_loader_pkg::EMPTY_WORD) || (word == boot_loader_pkg::EMPTY_WORD_SHORT);
    is_calib     = (word[31:16] == boot_loader_pkg::CALIB_TOP);
    is_debug_off = (word == boot_loader_pkg::DEBUG_OFF_WORD);
    is_timeout   = (word[boot_loader_pkg::NIB_MSB:boot_loader_pkg::NIB_LSB] == boot_loader_pkg::NIB_SYNC_TIMEOUT);
    is_spi_fast  = (word == boot_loader_pkg::SPI_FAST_WORD);
    calib_count  = word[boot_loader_pkg::CALIB_CNT_MSB:boot_loader_pkg::CALIB_CNT_LSB];
  end
endmodule // script_decoder
`default_nettype wire

// file: logic/otp_boot_script_loader.sv
// Boot sequencer: clock and supply bring-up, script interpreter, mode decision, copy and scan
`timescale 1ns/1ps
`default_nettype none
// Function
// - Script is valid only if its first word equals the start marker.
// - Address word at even position, data follows; write data to address.
// - Calibration header marks following words as software values, never written.
// - Header bits 15:8 give number of value words to skip.
// - Debugger-disable word keeps debug port off and rescans boot peripherals.
// - Top nibble 8 sets sync timeout in 100 us units from low 28 bits.
// - SPI clock word raises SPI boot clock from 2 MHz to 32 MHz.
// - Stop interpreting at the first unprogrammed word.
// - Boot runs after power-on, hardware reset, and wake with reset option.
// - First switch system clock from slow to fast RC oscillator.
// - In boost setup enable converter, wait for supply good before OTP.
// - Set UART rate to 115.2 kHz after OTP is up, then run script.
// - After script read both application flags to choose development or normal.
// - Copy OTP image into RAM starting at address zero.
// - Specific boot: alternate SPI pins, SPI master to flash, always try UART.
// - Specific boot UART variant selected from boot config bits 31:24.
// - Failed SPI flash boot returns to the normal peripheral scan.
// - Without specific flag, disable OTP then scan six interface steps in order.
// - Enable the fast crystal oscillator before any UART boot step.
// - Every boot interface step is bounded by a timeout.
// - Single-wire UART: half duplex on one pin, turn direction per phase.
// - Script holds at most sixty entries.
// - Variant byte 0 two-wire, 1 and 2 single-wire, others two-wire.
// - No source and no debugger-disable: endless loop with debug port on.
// - At completion clock is fast RC and pins return to reset defaults.
module otp_boot_script_loader #(
  parameter int          AW          = 13,
  parameter logic [12:0] SCRIPT_BASE = 13'h0000,
  parameter logic [12:0] HEADER_BASE = 13'h1ff0,
  parameter int          UNIT_CYC    = boot_loader_pkg::UNIT_CYCLES
) (
  // Clock and reset
  input  wire logic          clk_sys,
  input  wire logic          reset,
  // Boot triggers
  input  wire logic          por_event,
  input  wire logic          hw_reset_event,
  input  wire logic          wake_event,
  input  wire logic          wake_reset_enable,
  // Clock and power control
  output logic               fast_rc_oscillator,
  output logic               fast_crystal_oscillator,
  input  wire logic          boost_selected,
  output logic               boost_enable,
  input  wire logic          boost_vbat_ok,
  // OTP read port, one word per request
  output logic               otp_enable,
  output logic               otp_rd,
  output logic [AW-1:0]      otp_addr,
  input  wire logic          otp_rd_valid,
  input  wire logic [31:0]   otp_rd_data,
  // Register write port
  output logic               reg_wr,
  output logic [31:0]        reg_addr,
  output logic [31:0]        reg_wdata,
  // RAM copy port
  output logic               ram_wr,
  output logic [AW-1:0]      ram_addr,
  output logic [31:0]        ram_wdata,
  // Boot settings
  output logic [7:0]         uart_baud_div,
  output logic [27:0]        sync_char_timeout,
  output logic [1:0]         spi_clk_sel,
  output logic               spi_alt_pins,
  output logic               spi_master,
  output logic [1:0]         uart_mode,
  output logic               debug_enable,
  output logic               pins_default,
  // Boot interface scan
  output logic [2:0]         scan_step,
  output logic               step_start,
  input  wire logic          step_found,
  output logic               one_wire_tx,
  // Sequence status
  output logic               dev_mode,
  output logic               boot_done
);
  typedef enum logic [3:0] {
    S_IDLE, S_CLOCK, S_POWER, S_BAUD, S_FETCH, S_WAIT, S_MODE, S_COPY,
    S_SPECIFIC, S_STEP, S_STEP_WAIT, S_LOOP, S_DONE
  } state_t;

  state_t        state_reg;
  logic [AW-1:0] idx_reg;
  logic [AW-1:0] copy_len_reg;
  logic [1:0]    hdr_phase_reg;
  logic          started_reg;
  logic          pending_reg;
  logic [7:0]    skip_reg;
  logic          debug_off_reg;
  logic [31:0]   flag1_reg;
  logic [31:0]   bootcfg_reg;
  logic          specific_reg;
  logic          tmo_start;
  logic          tmo_expired;
  logic          d_empty;
  logic          d_calib;
  logic          d_debug;
  logic          d_tmo;
  logic          d_spi;
  logic [7:0]    d_count;
  logic          trigger;

  assign trigger = por_event || hw_reset_event || (wake_event && wake_reset_enable);

  script_decoder u_dec (
    .word         (otp_rd_data),
    .is_empty     (d_empty),
    .is_calib     (d_calib),
    .is_debug_off (d_debug),
    .is_timeout   (d_tmo),
    .is_spi_fast  (d_spi),
    .calib_count  (d_count)
  );

  boot_timeout #(.UNIT_CYC(UNIT_CYC)) u_tmo (
    .clk_sys (clk_sys),
    .reset   (reset),
    .start   (tmo_start),
    .limit   (sync_char_timeout),
    .expired (tmo_expired)
  );

  // Sequencer
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      state_reg <= S_IDLE;
      idx_reg   <= '0;
      hdr_phase_reg <= 2'h0;
      scan_step <= 3'h0;
    end
    else if (trigger)
    begin
      state_reg <= S_CLOCK;
      idx_reg   <= '0;
      hdr_phase_reg <= 2'h0;
      scan_step <= 3'h0;
    end
    else
    begin
      unique case (state_reg)
        S_IDLE: state_reg <= S_IDLE;
        S_CLOCK: state_reg <= S_POWER;
        S_POWER:
          if (!boost_selected || boost_vbat_ok)
            state_reg <= S_BAUD;
        S_BAUD: state_reg <= S_FETCH;
        S_FETCH: state_reg <= S_WAIT;
        S_WAIT:
          if (otp_rd_valid)
          begin
            if (hdr_phase_reg != 2'h0)
            begin
              hdr_phase_reg <= hdr_phase_reg + 2'h1;
              state_reg     <= (hdr_phase_reg == 2'h3) ? S_MODE : S_FETCH;
            end
            else if ((!started_reg && otp_rd_data != boot_loader_pkg::START_MARKER) ||
                     (!pending_reg && skip_reg == 8'h00 && d_empty) ||
                     (idx_reg == AW'(boot_loader_pkg::SCRIPT_DEPTH - 1)))
            begin
              hdr_phase_reg <= 2'h1;
              state_reg     <= S_FETCH;
            end
            else
            begin
              idx_reg   <= idx_reg + 1'b1;
              state_reg <= S_FETCH;
            end
          end
        S_MODE:
        begin
          idx_reg   <= '0;
          state_reg <= S_COPY;
        end
        S_COPY:
          if (idx_reg == copy_len_reg)
            state_reg <= (dev_mode && specific_reg) ? S_SPECIFIC : S_STEP;
          else if (otp_rd_valid)
            idx_reg <= idx_reg + 1'b1;
        S_SPECIFIC:
        begin
          scan_step <= 3'h0;
          state_reg <= S_STEP_WAIT;
        end
        S_STEP:
          state_reg <= S_STEP_WAIT;
        S_STEP_WAIT:
          if (step_found)
            state_reg <= S_DONE;
          else if (tmo_expired)
          begin
            if (scan_step == 3'(boot_loader_pkg::SCAN_STEPS - 1))
            begin
              scan_step <= 3'h0;
              state_reg <= debug_off_reg ? S_STEP : S_LOOP;
            end
            else
            begin
              scan_step <= scan_step + 3'h1;
              state_reg <= S_STEP;
            end
          end
        S_LOOP: state_reg <= S_LOOP;
        S_DONE: state_reg <= S_DONE;
      endcase
    end
  end

  // Script interpretation state
  always_ff @(posedge clk_sys)
  begin
    if (reset || trigger)
    begin
      started_reg <= 1'b0;
      pending_reg <= 1'b0;
      skip_reg <= 8'h00;
      debug_off_reg <= 1'b0;
      sync_char_timeout <= boot_loader_pkg::DEFAULT_TIMEOUT;
      spi_clk_sel <= boot_loader_pkg::SPI_CLK_2MHZ;
      reg_wr <= 1'b0;
      reg_addr <= 32'h00000000;
      reg_wdata <= 32'h00000000;
    end
    else
    begin
      reg_wr <= 1'b0;
      if (state_reg == S_WAIT && otp_rd_valid && hdr_phase_reg == 2'h0)
      begin
        if (!started_reg)
          started_reg <= 1'b1;
        else if (skip_reg != 8'h00)
          skip_reg <= skip_reg - 8'h01;
        else if (pending_reg)
        begin
          pending_reg <= 1'b0;
          reg_wr      <= 1'b1;
          reg_wdata   <= otp_rd_data;
        end
        else if (d_calib)
          skip_reg <= d_count;
        else if (d_debug)
          debug_off_reg <= 1'b1;
        else if (d_tmo)
          sync_char_timeout <= otp_rd_data[boot_loader_pkg::TIMEOUT_MSB:0];
        else if (d_spi)
          spi_clk_sel <= boot_loader_pkg::SPI_CLK_32MHZ;
        else if (!d_empty)
        begin
          pending_reg <= 1'b1;
          reg_addr    <= otp_rd_data;
        end
      end
    end
  end

  // Header words and mode decision
  always_ff @(posedge clk_sys)
  begin
    if (reset || trigger)
    begin
      flag1_reg <= 32'h00000000;
      bootcfg_reg <= 32'hffffffff;
      dev_mode <= 1'b1;
      copy_len_reg <= '0;
    end
    else if (state_reg == S_WAIT && otp_rd_valid && hdr_phase_reg != 2'h0)
    begin
      unique case (hdr_phase_reg)
        2'h1: flag1_reg <= otp_rd_data;
        2'h2: dev_mode <= !(flag1_reg == boot_loader_pkg::APP_FLAG1 &&
                            otp_rd_data == boot_loader_pkg::APP_FLAG2);
        2'h3: bootcfg_reg <= otp_rd_data;
        default: copy_len_reg <= '0;
      endcase
    end
    else if (state_reg == S_MODE)
      copy_len_reg <= AW'(boot_loader_pkg::SCRIPT_DEPTH);
  end

  assign specific_reg = (bootcfg_reg[7:0] == boot_loader_pkg::SPECIFIC_BOOT);

  // Outputs that follow the sequence; a restart drops what the last boot left on
  always_ff @(posedge clk_sys)
  begin
    if (reset || trigger)
    begin
      fast_rc_oscillator <= 1'b0;
      fast_crystal_oscillator <= 1'b0;
      boost_enable <= 1'b0;
      otp_enable <= 1'b0;
      uart_baud_div <= 8'h00;
      spi_alt_pins <= 1'b0;
      spi_master <= 1'b0;
      uart_mode <= 2'(boot_loader_pkg::UART_TWO_WIRE);
      debug_enable <= 1'b0;
      pins_default <= 1'b1;
      boot_done <= 1'b0;
    end
    else
    begin
      if (state_reg == S_CLOCK)
        fast_rc_oscillator <= 1'b1;
      if (state_reg == S_POWER && boost_selected)
        boost_enable <= 1'b1;
      if (state_reg == S_POWER && (!boost_selected || boost_vbat_ok))
        otp_enable <= 1'b1;
      if (state_reg == S_BAUD)
        uart_baud_div <= boot_loader_pkg::BAUD_115K2_DIV;
      if (state_reg == S_SPECIFIC)
      begin
        spi_alt_pins <= 1'b1;
        spi_master   <= 1'b1;
        unique case (bootcfg_reg[boot_loader_pkg::UART_SEL_MSB:boot_loader_pkg::UART_SEL_LSB])
          boot_loader_pkg::UART_SEL_ONE_A: uart_mode <= 2'(boot_loader_pkg::UART_ONE_WIRE_A);
          boot_loader_pkg::UART_SEL_ONE_B: uart_mode <= 2'(boot_loader_pkg::UART_ONE_WIRE_B);
          default: uart_mode <= 2'(boot_loader_pkg::UART_TWO_WIRE);
        endcase
      end
      if (state_reg == S_STEP || state_reg == S_SPECIFIC)
      begin
        otp_enable <= 1'b0;
        fast_crystal_oscillator <= 1'b1;
        pins_default <= 1'b0;
      end
      if (state_reg == S_STEP_WAIT && tmo_expired && scan_step == 3'h0)
      begin
        spi_alt_pins <= 1'b0;
        spi_master   <= 1'b0;
      end
      if (state_reg == S_LOOP)
        debug_enable <= 1'b1;
      if (state_reg == S_DONE || state_reg == S_LOOP)
      begin
        pins_default <= 1'b1;
        boot_done    <= 1'b1;
      end
    end
  end

  // Single-wire UART steps 1 and 2 turn the pin to transmit in the cycle their timeout expires
  assign one_wire_tx = (state_reg == S_STEP_WAIT) && (scan_step == 3'h1 || scan_step == 3'h2) &&
                       tmo_expired;
  assign tmo_start = (state_reg == S_STEP) || (state_reg == S_SPECIFIC);
  assign step_start = tmo_start;
  assign otp_rd = (state_reg == S_FETCH) || (state_reg == S_COPY && idx_reg != copy_len_reg);
  assign otp_addr = (hdr_phase_reg == 2'h1) ? HEADER_BASE + AW'(boot_loader_pkg::HDR_FLAG1) :
                    (hdr_phase_reg == 2'h2) ? HEADER_BASE + AW'(boot_loader_pkg::HDR_FLAG2) :
                    (hdr_phase_reg == 2'h3) ? HEADER_BASE + AW'(boot_loader_pkg::HDR_BOOTCFG) :
                    SCRIPT_BASE + idx_reg;
  assign ram_wr = (state_reg == S_COPY) && otp_rd_valid;
  assign ram_addr = idx_reg;
  assign ram_wdata = otp_rd_data;

  AST_CLOCK_FIRST: assert property (@(posedge clk_sys) disable iff (reset || trigger)
    (state_reg == S_CLOCK) |=> fast_rc_oscillator) else $error("fast clock not on");
  AST_SUPPLY_WAIT: assert property (@(posedge clk_sys) disable iff (reset || trigger)
    (state_reg == S_POWER && boost_selected && !boost_vbat_ok) |=> state_reg == S_POWER)
    else $error("left supply wait early");
  AST_TIMEOUT_SET: assert property (@(posedge clk_sys) disable iff (reset || trigger)
    (state_reg == S_WAIT && otp_rd_valid && started_reg && !pending_reg && skip_reg == 8'h00 &&
     hdr_phase_reg == 2'h0 && d_tmo && !d_calib && !d_debug) |=> sync_char_timeout == $past(otp_rd_data[27:0]))
    else $error("timeout not loaded");
  AST_CALIB_NOWRITE: assert property (@(posedge clk_sys) disable iff (reset)
    (skip_reg != 8'h00) |=> !reg_wr) else $error("calibration word written");
  AST_BAD_MARKER: assert property (@(posedge clk_sys) disable iff (reset || trigger)
    (state_reg == S_WAIT && otp_rd_valid && !started_reg && hdr_phase_reg == 2'h0 &&
     otp_rd_data != boot_loader_pkg::START_MARKER) |=> hdr_phase_reg == 2'h1) else $error("bad script ran");
  AST_CRYSTAL_UART: assert property (@(posedge clk_sys) disable iff (reset)
    (state_reg == S_STEP_WAIT) |-> fast_crystal_oscillator) else $error("crystal off in scan");
  AST_DEBUG_LOOP: assert property (@(posedge clk_sys) disable iff (reset || trigger)
    (state_reg == S_LOOP) |=> debug_enable && !debug_off_reg) else $error("loop without debug");
  AST_SPI_FAST: assert property (@(posedge clk_sys) disable iff (reset)
    (spi_clk_sel == boot_loader_pkg::SPI_CLK_32MHZ) |-> started_reg) else $error("spi fast unbidden");
endmodule // otp_boot_script_loader
`default_nettype wire

// file: testbench/otp_model.sv
// Model of the OTP array and of the serial boot hosts seen by the loader
`timescale 1ns/1ps
`default_nettype none
module otp_model (
  // Clock
  input  wire logic        clk_sys,
  // OTP read port
  input  wire logic        otp_enable,
  input  wire logic        otp_rd,
  input  wire logic [12:0] otp_addr,
  output logic             otp_rd_valid,
  output logic [31:0]      otp_rd_data,
  input  wire logic [3:0]  lat,
  // Boot hosts
  input  wire logic [2:0]  scan_step,
  input  wire logic [2:0]  host_step,
  input  wire logic        host_on,
  output logic             step_found
);
  logic [31:0] mem [8192];
  logic [12:0] addr_reg;
  int          wait_reg;

  initial
  begin
    otp_rd_valid = 1'b0;
    otp_rd_data  = 32'h00000000;
    addr_reg     = 13'h0000;
    wait_reg     = 0;
  end

  // Data inverts outside a valid cycle, so a stale word never passes as fresh
  always @(posedge clk_sys)
  begin
    otp_rd_valid <= 1'b0;
    otp_rd_data  <= ~otp_rd_data;
    if (wait_reg > 0)
    begin
      wait_reg <= wait_reg - 1;
      if (wait_reg == 1)
      begin
        otp_rd_valid <= 1'b1;
        otp_rd_data  <= mem[addr_reg];
      end
    end
    // A read held through its answer cycle is still the same read
    else if (otp_rd && otp_enable && !otp_rd_valid)
    begin
      addr_reg <= otp_addr;
      wait_reg <= int'(lat);
    end
  end

  // Host answers only while its own step is scanned
  assign step_found = host_on && (scan_step == host_step);
endmodule // otp_model
`default_nettype wire

// file: testbench/tb_otp_boot_script_loader.sv
// Self-checking bench for the boot script loader
`timescale 1ns/1ps
`default_nettype none
module tb_otp_boot_script_loader;
  localparam int HDR = 'h1ff0;
  logic        clk_sys = 1'b0, reset = 1'b1, por_event = 1'b0, hw_reset_event = 1'b0, wake_event = 1'b0;
  logic        wake_reset_enable = 1'b0, boost_selected = 1'b0, boost_vbat_ok = 1'b0, host_on = 1'b0;
  logic [2:0]  host_step = 3'h0;
  logic [3:0]  lat = 4'h1;
  logic        fast_rc_oscillator, fast_crystal_oscillator, boost_enable, otp_enable, otp_rd, otp_rd_valid;
  logic        reg_wr, ram_wr, spi_alt_pins, spi_master, debug_enable, pins_default, step_start, step_found;
  logic        one_wire_tx, dev_mode, boot_done;
  logic [12:0] otp_addr, ram_addr;
  logic [31:0] otp_rd_data, reg_addr, reg_wdata, ram_wdata;
  logic [7:0]  uart_baud_div;
  logic [27:0] sync_char_timeout;
  logic [1:0]  spi_clk_sel, uart_mode;
  logic [2:0]  scan_step;
  int          n_errors = 0, compares = 0, cycles = 0, n_ram = 0, bad_ram = 0, n_rd = 0;
  logic [31:0] wr_q[$], scr[$], exp[$];
  logic [2:0]  step_q[$], tx_q[$];

  always #50 clk_sys = ~clk_sys;

  otp_boot_script_loader #(.UNIT_CYC(2)) otp_boot_script_loader_i (
    .clk_sys, .reset, .por_event, .hw_reset_event, .wake_event, .wake_reset_enable,
    .fast_rc_oscillator, .fast_crystal_oscillator, .boost_selected, .boost_enable, .boost_vbat_ok,
    .otp_enable, .otp_rd, .otp_addr, .otp_rd_valid, .otp_rd_data, .reg_wr, .reg_addr, .reg_wdata,
    .ram_wr, .ram_addr, .ram_wdata, .uart_baud_div, .sync_char_timeout, .spi_clk_sel, .spi_alt_pins,
    .spi_master, .uart_mode, .debug_enable, .pins_default, .scan_step, .step_start, .step_found,
    .one_wire_tx, .dev_mode, .boot_done);

  otp_model otp_model_i (
    .clk_sys, .otp_enable, .otp_rd, .otp_addr, .otp_rd_valid, .otp_rd_data, .lat,
    .scan_step, .host_step, .host_on, .step_found);

  // Monitors; the cycle ceiling covers about fifty-eight full boots
  always @(posedge clk_sys)
  begin
    cycles++;
    if (reg_wr)
    begin
      wr_q.push_back(reg_addr);
      wr_q.push_back(reg_wdata);
    end
    if (ram_wr && (ram_addr !== n_ram[12:0] || ram_wdata !== otp_model_i.mem[ram_addr])) bad_ram++;
    if (one_wire_tx) tx_q.push_back(scan_step);
    if (ram_wr) n_ram++;
    if (otp_rd) n_rd++;
    if (step_start) step_q.push_back(scan_step);
    if (cycles == 40000)
    begin
      n_errors++;
      summarize();
    end
  end

  task automatic summarize();
    if (n_errors == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] want);
    compares++;
    if (got !== want)
    begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, want);
    end
  endtask

  // Image: script from word zero, header flags and boot config
  task automatic load(input logic [31:0] f1, input logic [31:0] f2, input logic [31:0] cfg);
    for (int i = 0; i < 8192; i++) otp_model_i.mem[i] = 32'hffffffff;
    foreach (scr[i]) otp_model_i.mem[i] = scr[i];
    otp_model_i.mem[HDR] = f1;
    otp_model_i.mem[HDR + 1] = f2;
    otp_model_i.mem[HDR + 2] = cfg;
  endtask

  task automatic boot(input bit hw);
    wr_q.delete();
    step_q.delete();
    tx_q.delete();
    n_ram = 0;
    bad_ram = 0;
    n_rd = 0;
    @(negedge clk_sys) reset = 1'b1;
    @(negedge clk_sys) reset = 1'b0;
    @(negedge clk_sys) por_event = !hw;
    hw_reset_event = hw;
    @(negedge clk_sys) por_event = 1'b0;
    hw_reset_event = 1'b0;
  endtask

  task automatic wait_steps(input int n, input int limit);
    for (int i = 0; i < limit && step_q.size() < n; i++) @(negedge clk_sys);
  endtask

  task automatic t_triggers();
    @(negedge clk_sys) reset = 1'b1;
    @(negedge clk_sys) reset = 1'b0;
    check(sync_char_timeout, 32'h28);
    wake_event = 1'b1;
    @(negedge clk_sys) wake_event = 1'b0;
    repeat (6) @(negedge clk_sys);
    check(fast_rc_oscillator, 1'b0);
    wake_reset_enable = 1'b1;
    wake_event = 1'b1;
    @(negedge clk_sys) wake_event = 1'b0;
    repeat (4) @(negedge clk_sys);
    check(fast_rc_oscillator, 1'b1);
    wake_reset_enable = 1'b0;
  endtask

  task automatic t_script();
    scr = '{32'ha5a5a5a5, 32'h80000005, 32'h00001000, 32'h11111111, 32'h90000301, 32'h00002000, 32'h22222222,
            32'h00003000, 32'h00004000, 32'h44444444, 32'ha0000000, 32'hffffffff, 32'h00005000, 32'h55555555};
    exp = '{32'h00001000, 32'h11111111, 32'h00004000, 32'h44444444};
    lat = 4'h3;
    load(32'h1234a5a5, 32'ha5a51234, 32'hffffffff);
    boot(1'b1);
    wait_steps(1, 4000);
    check(uart_baud_div, 8'h57);
    check(wr_q.size(), 4);
    foreach (exp[i]) check(wr_q[i], exp[i]);
    check(spi_clk_sel, boot_loader_pkg::SPI_CLK_32MHZ);
    check(sync_char_timeout, 32'h5);
    wait_steps(2, 14);
    check(step_q.size(), 2);
    lat = 4'h1;
  endtask

  task automatic t_bad_marker();
    scr = '{32'ha5a5a5a4, 32'h80000005, 32'h00001000, 32'h11111111};
    load(32'h1234a5a5, 32'ha5a51234, 32'hffffffff);
    boot(1'b0);
    wait_steps(1, 3000);
    check(wr_q.size(), 0);
    check(sync_char_timeout, 32'h28);
  endtask

  task automatic t_boost();
    boost_selected = 1'b1;
    boot(1'b0);
    repeat (30) @(negedge clk_sys);
    check(boost_enable, 1'b1);
    check(n_rd, 0);
    boost_vbat_ok = 1'b1;
    wait_steps(1, 3000);
    check(n_rd > 0, 1);
    boost_selected = 1'b0;
  endtask

  task automatic t_normal(input bit dbg_off);
    scr = '{32'ha5a5a5a5, dbg_off ? boot_loader_pkg::DEBUG_OFF_WORD : 32'hffffffff};
    load(dbg_off ? 32'hffffffff : 32'h1234a5a5, 32'ha5a51234, 32'hffffffff);
    boot(1'b0);
    wait_steps(8, 3000);
    for (int i = 0; i < 8 && step_q.size() == 6 && boot_done !== 1'b1; i++) @(negedge clk_sys);
    check(dev_mode, dbg_off);
    check(n_ram, 60);
    check(bad_ram, 0);
    for (int i = 0; i < 6; i++) check(step_q[i], i);
    check(step_q.size(), dbg_off ? 8 : 6);
    check(debug_enable, !dbg_off);
    check(fast_crystal_oscillator, 1'b1);
    check(fast_rc_oscillator, 1'b1);
    check(pins_default, !dbg_off);
    check(otp_enable, 1'b0);
  endtask

  task automatic t_found();
    scr = '{32'ha5a5a5a5, 32'h80000005};
    for (int i = 2; i < 62; i++) scr.push_back(32'(i));
    load(32'h1234a5a5, 32'ha5a51234, 32'h010000aa);
    host_step = 3'h3;
    host_on = 1'b1;
    boot(1'b0);
    wait_steps(4, 3000);
    repeat (2) @(negedge clk_sys);
    check(wr_q.size(), 58);
    check(wr_q[57], 32'h3b);
    check(uart_mode, 2'h0);
    check(boot_done, 1'b1);
    check(pins_default, 1'b1);
    check(debug_enable, 1'b0);
    check(step_q.size(), 4);
    check(bad_ram, 0);
    check(tx_q.size(), 2);
    foreach (tx_q[i]) check(tx_q[i], i + 1);
    host_on = 1'b0;
  endtask

  task automatic t_specific();
    logic [7:0] sel[4] = '{8'h00, 8'h01, 8'h02, 8'h07};
    logic [1:0] mode[4] = '{2'h0, 2'h1, 2'h2, 2'h0};
    scr = '{32'ha5a5a5a5};
    foreach (sel[i])
    begin
      load(32'hffffffff, 32'hffffffff, {sel[i], 24'h0000aa});
      boot(1'b0);
      wait_steps(1, 3000);
      check(spi_alt_pins, 1'b1);
      check(spi_master, 1'b1);
      check(uart_mode, mode[i]);
      wait_steps(2, 200);
      check(spi_alt_pins, 1'b0);
    end
  endtask

  initial
  begin
    repeat (20) @(negedge clk_sys);
    reset = 1'b0;
    t_triggers();
    t_script();
    t_bad_marker();
    t_boost();
    t_normal(1'b0);
    t_normal(1'b1);
    t_found();
    t_specific();
    summarize();
  end
endmodule // tb_otp_boot_script_loader
`default_nettype wire
